/* design/dmcfg_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module dmcfg_regs (
  input  wire logic                                  clock,
  input  wire logic                                  rstn,
  input  wire logic [7:0]                            regAddr,
  input  wire logic [7:0]                            regWrData,
  input  wire logic                                  regWrEn,
  input  wire logic                                  regRdEn,
  output logic [7:0]                                 regRdData,
  output logic                                       regRdValid,
  input  wire logic                                  inputDiagAny,
  input  wire logic                                  convStart,
  input  wire logic                                  resultValid,
  input  wire logic [dmcfg_pkg::DMCFG_RESULT_W-1:0]  resultData,
  input  wire logic [3:0]                            resultChannel,
  input  wire logic                                  inOvFault,
  input  wire logic                                  inShortBatFault,
  output logic [2:0]                                 biasOvMargin,
  output logic [2:0]                                 inToBiasMargin,
  output logic [2:0]                                 inOvMargin,
  output dmcfg_pkg::dmcfg_filt_t                     supplyFilter,
  output dmcfg_pkg::dmcfg_filt_t                     batFilter,
  output logic [dmcfg_pkg::DMCFG_NUM_CHAN-1:0]       chanEnable,
  output logic                                       ovFaultReport,
  output logic                                       batShortFaultReport
);
  import dmcfg_pkg::*;

  typedef struct packed {
    logic [7:0]                biasOvCfg;
    logic [7:0]                inFaultCfg;
    logic [7:0]                chanEnCfg;
    logic [7:0]                filterCfg;
    logic [2:0]                actBiasOv;
    logic [2:0]                actInBias;
    logic [2:0]                actInOv;
    dmcfg_filt_t               actSupFilt;
    dmcfg_filt_t               actBatFilt;
    logic                      actForce;
    logic [DMCFG_NUM_MANUAL-1:0] actManEn;
    logic                      actSupOn;
    logic                      actAuxOn;
    logic                      actMerge;
    logic [7:0]                batHigh;
    logic [3:0]                batLow;
    logic [7:0]                rdData;
    logic                      rdValid;
    logic [DMCFG_NUM_CHAN-1:0] chanEn;
    logic                      ovRep;
    logic                      batShortRep;
  } dmcfg_state_t;

  localparam dmcfg_state_t DMCFG_STATE_RST = '{
    biasOvCfg:   DMCFG_RST_BIAS_OV,
    inFaultCfg:  DMCFG_RST_IN_FAULT,
    chanEnCfg:   DMCFG_RST_CHAN_EN,
    filterCfg:   DMCFG_RST_FILTER,
    actBiasOv:   DMCFG_RST_BIAS_OV[DMCFG_BIAS_OV_LSB +: 3],
    actInBias:   DMCFG_RST_IN_FAULT[DMCFG_IN_BIAS_LSB +: 3],
    actInOv:     DMCFG_RST_IN_FAULT[DMCFG_IN_OV_LSB +: 3],
    actSupFilt:  dmcfg_filt_t'(DMCFG_RST_FILTER[DMCFG_SUP_FILT_LSB +: 2]),
    actBatFilt:  dmcfg_filt_t'(DMCFG_RST_FILTER[DMCFG_BAT_FILT_LSB +: 2]),
    actForce:    DMCFG_RST_CHAN_EN[DMCFG_FORCE_BIT],
    actManEn:    DMCFG_RST_CHAN_EN[DMCFG_EN_TEMP_BIT +: DMCFG_NUM_MANUAL],
    actSupOn:    DMCFG_RST_CHAN_EN[DMCFG_EN_SUPPLY_BIT],
    actAuxOn:    DMCFG_RST_CHAN_EN[DMCFG_EN_AUX_BIT],
    actMerge:    DMCFG_RST_FILTER[DMCFG_MERGE_BIT],
    batHigh:     DMCFG_RST_BAT_HIGH,
    batLow:      DMCFG_RST_BAT_LOW,
    rdData:      DMCFG_RD_UNMAPPED,
    rdValid:     1'b0,
    chanEn:      '0,
    ovRep:       1'b0,
    batShortRep: 1'b0
  };

  dmcfg_state_t st_r;
  dmcfg_state_t st_nxt;

  logic [DMCFG_NUM_CHAN-1:0] chanEnNxt;
  logic                      ovRepNxt;
  logic                      batShortRepNxt;

  dmcfg_active_if actIf ();

  // reserved bits are forced to their reset value of zero on every write
  function automatic logic [7:0] maskWrite(input logic [7:0] data, input logic [7:0] mask);
    maskWrite = data & mask;
  endfunction

  // illegal input overvoltage codes are clamped so the comparator never sees them
  function automatic logic [2:0] legalInOv(input logic [2:0] code);
    legalInOv = (code > DMCFG_IN_OV_MAX) ? DMCFG_IN_OV_MAX : code;
  endfunction

  function automatic logic [7:0] readReg(input dmcfg_state_t s, input logic [7:0] addr);
    unique case (addr)
      DMCFG_ADDR_BIAS_OV:  readReg = s.biasOvCfg;
      DMCFG_ADDR_IN_FAULT: readReg = s.inFaultCfg;
      DMCFG_ADDR_CHAN_EN:  readReg = s.chanEnCfg;
      DMCFG_ADDR_FILTER:   readReg = s.filterCfg;
      DMCFG_ADDR_BAT_HIGH: readReg = s.batHigh;
      DMCFG_ADDR_BAT_LOW:  readReg = {s.batLow, DMCFG_BAT_CHAN_ID};
      default:             readReg = DMCFG_RD_UNMAPPED;
    endcase
  endfunction

  assign actIf.manualEn       = st_r.actManEn;
  assign actIf.manualOverride = st_r.actForce;
  assign actIf.supplyOn       = st_r.actSupOn;
  assign actIf.auxOn          = st_r.actAuxOn;
  assign actIf.shortMerge     = st_r.actMerge;

  dmcfg_chan_enable u_chan_enable (
    .cfg          (actIf.sink),
    .inputDiagAny (inputDiagAny),
    .chanEnNxt    (chanEnNxt)
  );

  dmcfg_fault_merge u_fault_merge (
    .cfg             (actIf.sink),
    .inOvFault       (inOvFault),
    .inShortBatFault (inShortBatFault),
    .ovRepNxt        (ovRepNxt),
    .batShortRepNxt  (batShortRepNxt)
  );

  always_comb begin
    st_nxt = st_r;

    // host writes; read-only and unmapped offsets are ignored
    if (regWrEn) begin
      unique case (regAddr)
        DMCFG_ADDR_BIAS_OV: begin
          st_nxt.biasOvCfg = maskWrite(regWrData, DMCFG_WMASK_BIAS_OV);
        end
        DMCFG_ADDR_IN_FAULT: begin
          st_nxt.inFaultCfg = maskWrite(regWrData, DMCFG_WMASK_IN_FAULT);
        end
        DMCFG_ADDR_CHAN_EN: begin
          st_nxt.chanEnCfg = maskWrite(regWrData, DMCFG_WMASK_CHAN_EN);
        end
        DMCFG_ADDR_FILTER: begin
          st_nxt.filterCfg = maskWrite(regWrData, DMCFG_WMASK_FILTER);
        end
        default: begin
        end
      endcase
    end

    // read answers one cycle later from the state before this cycle's write
    st_nxt.rdValid = regRdEn;
    if (regRdEn) begin
      st_nxt.rdData = readReg(st_r, regAddr);
    end

    // snapshot only at a conversion start so a running one is never disturbed
    if (convStart) begin
      st_nxt.actBiasOv  = st_r.biasOvCfg[DMCFG_BIAS_OV_LSB +: 3];
      st_nxt.actInBias  = st_r.inFaultCfg[DMCFG_IN_BIAS_LSB +: 3];
      st_nxt.actInOv    = legalInOv(st_r.inFaultCfg[DMCFG_IN_OV_LSB +: 3]);
      st_nxt.actSupFilt = dmcfg_filt_t'(st_r.filterCfg[DMCFG_SUP_FILT_LSB +: 2]);
      st_nxt.actBatFilt = dmcfg_filt_t'(st_r.filterCfg[DMCFG_BAT_FILT_LSB +: 2]);
      st_nxt.actMerge   = st_r.filterCfg[DMCFG_MERGE_BIT];
      st_nxt.actForce   = st_r.chanEnCfg[DMCFG_FORCE_BIT];
      st_nxt.actManEn   = st_r.chanEnCfg[DMCFG_EN_TEMP_BIT +: DMCFG_NUM_MANUAL];
      st_nxt.actSupOn   = st_r.chanEnCfg[DMCFG_EN_SUPPLY_BIT];
      st_nxt.actAuxOn   = st_r.chanEnCfg[DMCFG_EN_AUX_BIT];
    end

    // battery result: both halves land in the same cycle so they never tear
    if (resultValid && (resultChannel == DMCFG_BAT_CHAN_ID)) begin
      st_nxt.batHigh = resultData[DMCFG_RESULT_W-1 -: 8];
      st_nxt.batLow  = resultData[3:0];
    end

    st_nxt.chanEn      = chanEnNxt;
    st_nxt.ovRep       = ovRepNxt;
    st_nxt.batShortRep = batShortRepNxt;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= DMCFG_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData           = st_r.rdData;
  assign regRdValid          = st_r.rdValid;
  assign biasOvMargin        = st_r.actBiasOv;
  assign inToBiasMargin      = st_r.actInBias;
  assign inOvMargin          = st_r.actInOv;
  assign supplyFilter        = st_r.actSupFilt;
  assign batFilter           = st_r.actBatFilt;
  assign chanEnable          = st_r.chanEn;
  assign ovFaultReport       = st_r.ovRep;
  assign batShortFaultReport = st_r.batShortRep;

endmodule
`default_nettype wire

/* design/dmcfg_pkg.sv */
package dmcfg_pkg;

  // register offsets
  localparam logic [7:0] DMCFG_ADDR_BIAS_OV   = 8'h51;
  localparam logic [7:0] DMCFG_ADDR_IN_FAULT  = 8'h52;
  localparam logic [7:0] DMCFG_ADDR_CHAN_EN   = 8'h53;
  localparam logic [7:0] DMCFG_ADDR_FILTER    = 8'h54;
  localparam logic [7:0] DMCFG_ADDR_BAT_HIGH  = 8'h56;
  localparam logic [7:0] DMCFG_ADDR_BAT_LOW   = 8'h57;

  // reset values
  localparam logic [7:0] DMCFG_RST_BIAS_OV    = 8'h40;
  localparam logic [7:0] DMCFG_RST_IN_FAULT   = 8'h44;
  localparam logic [7:0] DMCFG_RST_CHAN_EN    = 8'h00;
  localparam logic [7:0] DMCFG_RST_FILTER     = 8'h48;
  localparam logic [7:0] DMCFG_RST_BAT_HIGH   = 8'h00;
  localparam logic [3:0] DMCFG_RST_BAT_LOW    = 4'h0;
  localparam logic [7:0] DMCFG_RD_UNMAPPED    = 8'h00;

  // writable bits; all others are reserved, read as zero
  localparam logic [7:0] DMCFG_WMASK_BIAS_OV  = 8'he0;
  localparam logic [7:0] DMCFG_WMASK_IN_FAULT = 8'hfc;
  localparam logic [7:0] DMCFG_WMASK_CHAN_EN  = 8'hfe;
  localparam logic [7:0] DMCFG_WMASK_FILTER   = 8'h6d;

  // field positions
  localparam int DMCFG_BIAS_OV_LSB    = 5;
  localparam int DMCFG_IN_BIAS_LSB    = 5;
  localparam int DMCFG_IN_OV_LSB      = 2;
  localparam int DMCFG_FORCE_BIT      = 7;
  localparam int DMCFG_EN_LOAD_BIT    = 6;
  localparam int DMCFG_EN_BIAS_BIT    = 5;
  localparam int DMCFG_EN_BAT_BIT     = 4;
  localparam int DMCFG_EN_TEMP_BIT    = 3;
  localparam int DMCFG_EN_SUPPLY_BIT  = 2;
  localparam int DMCFG_EN_AUX_BIT     = 1;
  localparam int DMCFG_SUP_FILT_LSB   = 5;
  localparam int DMCFG_BAT_FILT_LSB   = 2;
  localparam int DMCFG_MERGE_BIT      = 0;

  // channel enable vector order: load, bias, battery, temp, supply, aux
  localparam int DMCFG_NUM_MANUAL     = 4;
  localparam int DMCFG_NUM_CHAN       = 6;

  // margin encoding and limits
  localparam int         DMCFG_MARGIN_STEP_MV = 30;
  localparam logic [2:0] DMCFG_IN_OV_MAX      = 3'h1;

  // result layout
  localparam logic [3:0] DMCFG_BAT_CHAN_ID    = 4'h0;
  localparam int         DMCFG_RESULT_W       = 12;

  typedef enum logic [1:0] {
    DMCFG_FILT_3M5,
    DMCFG_FILT_200K,
    DMCFG_FILT_100K,
    DMCFG_FILT_NONE
  } dmcfg_filt_t;

endpackage

/* design/dmcfg_active_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dmcfg_active_if;
  import dmcfg_pkg::*;
  logic [DMCFG_NUM_MANUAL-1:0] manualEn;
  logic                        manualOverride;
  logic                        supplyOn;
  logic                        auxOn;
  logic                        shortMerge;

  modport src  (output manualEn, manualOverride, supplyOn, auxOn, shortMerge);
  modport sink (input  manualEn, manualOverride, supplyOn, auxOn, shortMerge);
endinterface
`default_nettype wire

/* design/dmcfg_chan_enable.sv */
`timescale 1ns/1ps
`default_nettype none
module dmcfg_chan_enable (
  dmcfg_active_if.sink                          cfg,
  input  wire logic                             inputDiagAny,
  output logic [dmcfg_pkg::DMCFG_NUM_CHAN-1:0]  chanEnNxt
);
  import dmcfg_pkg::*;

  genvar i;
  generate
    for (i = 0; i < DMCFG_NUM_MANUAL; i++) begin : g_man
      // auto mode follows any input diagnostic, manual mode its own bit
      assign chanEnNxt[DMCFG_NUM_CHAN-1-i] = cfg.manualOverride ? cfg.manualEn[DMCFG_NUM_MANUAL-1-i]
                                                                : inputDiagAny;
    end
  endgenerate

  assign chanEnNxt[1] = cfg.supplyOn;
  assign chanEnNxt[0] = cfg.auxOn;
endmodule
`default_nettype wire

/* design/dmcfg_fault_merge.sv */
`timescale 1ns/1ps
`default_nettype none
module dmcfg_fault_merge (
  dmcfg_active_if.sink cfg,
  input  wire logic    inOvFault,
  input  wire logic    inShortBatFault,
  output logic         ovRepNxt,
  output logic         batShortRepNxt
);
  import dmcfg_pkg::*;

  always_comb begin
    if (cfg.shortMerge) begin
      // overvoltage folds into the battery short, nothing left separate
      ovRepNxt       = 1'b0;
      batShortRepNxt = inOvFault | inShortBatFault;
    end else begin
      ovRepNxt       = inOvFault;
      batShortRepNxt = inShortBatFault;
    end
  end
endmodule
`default_nettype wire

/* bench/dmcfg_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dmcfg_regs_chk (
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic [7:0]             regAddr,
  input wire logic                   regRdEn,
  input wire logic [7:0]             regRdData,
  input wire logic                   regRdValid,
  input wire logic                   convStart,
  input wire logic                   inOvFault,
  input wire logic                   inShortBatFault,
  input wire logic [2:0]             biasOvMargin,
  input wire logic [2:0]             inToBiasMargin,
  input wire logic [2:0]             inOvMargin,
  input var  dmcfg_pkg::dmcfg_filt_t supplyFilter,
  input var  dmcfg_pkg::dmcfg_filt_t batFilter,
  input wire logic [5:0]             chanEnable,
  input wire logic                   ovFaultReport,
  input wire logic                   batShortFaultReport
);
  import dmcfg_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  AST_RD_VALID: assert property (regRdEn |=> regRdValid)
    else $error("read strobe gave no valid");
  AST_RD_QUIET: assert property (!regRdEn |=> !regRdValid)
    else $error("valid without read strobe");
  AST_RSV_FILT: assert property (regRdEn && regAddr == 8'h54 |=> (regRdData & 8'h92) == 8'h00)
    else $error("reserved filter bits not zero");
  AST_RSV_BIAS: assert property (regRdEn && regAddr == 8'h51 |=> regRdData[4:0] == 5'h00)
    else $error("reserved margin bits not zero");
  AST_BAT_ID: assert property (regRdEn && regAddr == 8'h57 |=> regRdData[3:0] == 4'h0)
    else $error("battery channel id not zero");
  AST_OV_CLAMP: assert property (inOvMargin <= 3'h1)
    else $error("input overvoltage margin above one step");
  AST_CFG_HOLD: assert property (!convStart |=> $stable({biasOvMargin, inToBiasMargin, supplyFilter, batFilter}))
    else $error("config moved without conversion start");
  AST_EN_HOLD: assert property (!convStart |-> ##2 $stable(chanEnable[1:0]))
    else $error("supply or aux enable moved without conversion");
  AST_OV_SRC: assert property (ovFaultReport |-> $past(inOvFault))
    else $error("overvoltage report without cause");
  AST_BAT_SRC: assert property (batShortFaultReport |-> $past(inShortBatFault) || $past(inOvFault))
    else $error("battery short report without cause");
endmodule
`default_nettype wire

/* bench/dmcfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dmcfg_host (
  input  wire logic       clock,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // callers keep reserved fields at zero except when probing masking
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clock);
    #1 regWrEn = 1'b0;
    regWrData = ~d;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clock);
    #1 regRdEn = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d = regRdData;
      end else begin
        @(posedge clock);
        #1;
      end
    end
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

/* bench/test_dmcfg_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_dmcfg_regs;
  import dmcfg_pkg::*;
  logic        clock, rstn, regWrEn, regRdEn, regRdValid, inputDiagAny, convStart;
  logic        resultValid, inOvFault, inShortBatFault, ovFaultReport, batShortFaultReport;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [11:0] resultData;
  logic [3:0]  resultChannel;
  logic [2:0]  biasOvMargin, inToBiasMargin, inOvMargin;
  logic [5:0]  chanEnable;
  dmcfg_filt_t supplyFilter, batFilter;
  int          failures, samplesChecked;
  dmcfg_regs u_dmcfg_regs (.clock(clock), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .inputDiagAny(inputDiagAny), .convStart(convStart),
    .resultValid(resultValid), .resultData(resultData), .resultChannel(resultChannel),
    .inOvFault(inOvFault), .inShortBatFault(inShortBatFault), .biasOvMargin(biasOvMargin),
    .inToBiasMargin(inToBiasMargin), .inOvMargin(inOvMargin), .supplyFilter(supplyFilter),
    .batFilter(batFilter), .chanEnable(chanEnable), .ovFaultReport(ovFaultReport),
    .batShortFaultReport(batShortFaultReport));
  dmcfg_host u_dmcfg_host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test;
    $display("checked %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    u_dmcfg_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      $display("[ERR] regRdValid exp 1 got 0");
      failures++;
      end_of_test();
    end else `CHK("regRdData", e, d)
  endtask
  // snapshot lands one cycle after the start, enables one more
  task automatic conv;
    convStart = 1'b1;
    step(1);
    convStart = 1'b0;
    step(2);
  endtask
  task automatic t_reset;
    rchk(8'h51, 8'h40);
    rchk(8'h52, 8'h44);
    rchk(8'h53, 8'h00);
    rchk(8'h54, 8'h48);
    rchk(8'h56, 8'h00);
    rchk(8'h57, 8'h00);
    rchk(8'h55, 8'h00);
    `CHK("inOvMargin", 3'h1, inOvMargin)
    `CHK("filters", 4'ha, {supplyFilter, batFilter})
    `CHK("resetMargins", 6'h12, {biasOvMargin, inToBiasMargin})
    `CHK("resetEnables", 6'h00, chanEnable)
    $display("t_reset done");
  endtask
  task automatic t_reserved;
    logic [7:0] a[4] = '{8'h51, 8'h52, 8'h53, 8'h54};
    logic [7:0] m[4] = '{8'he0, 8'hfc, 8'hfe, 8'h6d};
    foreach (a[i]) begin
      u_dmcfg_host.wr(a[i], 8'hff);
      rchk(a[i], m[i]);
    end
    u_dmcfg_host.wr(8'h56, 8'hff);
    rchk(8'h56, 8'h00);
    u_dmcfg_host.wr(8'h57, 8'hff);
    rchk(8'h57, 8'h00);
    u_dmcfg_host.wr(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
    `CHK("heldMargin", 3'h2, biasOvMargin)
    conv();
    `CHK("inOvClamp", 3'h1, inOvMargin)
    $display("t_reserved done");
  endtask
  task automatic t_codes;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      u_dmcfg_host.wr(8'h51, {k, 5'h00});
      u_dmcfg_host.wr(8'h52, {k, 2'b00, k[0], 2'b00});
      u_dmcfg_host.wr(8'h54, {1'b0, k[1:0], 1'b0, ~k[1:0], 2'b00});
      conv();
      `CHK("biasOvMargin", k, biasOvMargin)
      `CHK("inToBiasMargin", k, inToBiasMargin)
      `CHK("inOvMargin", {2'b00, k[0]}, inOvMargin)
      `CHK("supplyFilter", k[1:0], supplyFilter)
      `CHK("batFilter", ~k[1:0], batFilter)
    end
    $display("t_codes done");
  endtask
  task automatic t_merge;
    inOvFault = 1'b1;
    u_dmcfg_host.wr(8'h54, 8'h49);
    `CHK("ovBeforeConv", 1'b1, ovFaultReport)
    conv();
    `CHK("ovMerged", 1'b0, ovFaultReport)
    `CHK("batMerged", 1'b1, batShortFaultReport)
    u_dmcfg_host.wr(8'h54, 8'h48);
    conv();
    `CHK("ovSplit", 1'b1, ovFaultReport)
    `CHK("batSplit", 1'b0, batShortFaultReport)
    inOvFault = 1'b0;
    inShortBatFault = 1'b1;
    step(2);
    `CHK("shortSplit", 2'b01, {ovFaultReport, batShortFaultReport})
    inShortBatFault = 1'b0;
    $display("t_merge done");
  endtask
  task automatic t_enable;
    u_dmcfg_host.wr(8'h53, 8'h7c);
    conv();
    `CHK("autoIdle", 6'h02, chanEnable)
    inputDiagAny = 1'b1;
    step(2);
    `CHK("autoBusy", 6'h3e, chanEnable)
    u_dmcfg_host.wr(8'h53, 8'hd2);
    conv();
    `CHK("manual", 6'h29, chanEnable)
    inputDiagAny = 1'b0;
    step(2);
    `CHK("manualIdle", 6'h29, chanEnable)
    $display("t_enable done");
  endtask
  task automatic t_result;
    resultData = 12'habc;
    resultValid = 1'b1;
    step(1);
    resultValid = 1'b0;
    resultData = 12'h123;
    rchk(8'h56, 8'hab);
    rchk(8'h57, 8'hc0);
    resultChannel = 4'h1;
    resultValid = 1'b1;
    step(1);
    resultValid = 1'b0;
    rchk(8'h56, 8'hab);
    rstn = 1'b0;
    step(2);
    rstn = 1'b1;
    rchk(8'h56, 8'h00);
    `CHK("resetFilters", 4'ha, {supplyFilter, batFilter})
    $display("t_result done");
  endtask
  initial begin
    {rstn, inputDiagAny, convStart, resultValid, inOvFault, inShortBatFault} = 6'h00;
    resultData = 12'h000;
    resultChannel = 4'h0;
    step(5);
    rstn = 1'b1;
    t_reset();
    t_reserved();
    t_codes();
    t_merge();
    t_enable();
    t_result();
    end_of_test();
  end
endmodule
bind dmcfg_regs dmcfg_regs_chk u_dmcfg_regs_chk (.clock(clock), .rstn(rstn), .regAddr(regAddr),
  .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .convStart(convStart),
  .inOvFault(inOvFault), .inShortBatFault(inShortBatFault), .biasOvMargin(biasOvMargin),
  .inToBiasMargin(inToBiasMargin), .inOvMargin(inOvMargin), .supplyFilter(supplyFilter),
  .batFilter(batFilter), .chanEnable(chanEnable), .ovFaultReport(ovFaultReport),
  .batShortFaultReport(batShortFaultReport));
`default_nettype wire
